// ---- rtl/interp_pkg.sv ----
// constants, types and shared arithmetic of the interpolation filter chain
package interp_pkg;

	// ------------------------------------------------------------
	// datapath types
	// ------------------------------------------------------------
	localparam int DATA_W = 16; // datapath sample width
	localparam int ACC_W = 40; // headroom for 15 pair products
	typedef logic signed [DATA_W-1:0] smp_t; // one channel sample
	typedef logic signed [ACC_W-1:0] acc_t; // accumulator
	typedef struct packed {
		smp_t i; // in-phase channel
		smp_t q; // quadrature channel
	} sample_s;
	localparam int SAMPLE_W = $bits(sample_s); // fifo word width

	// ------------------------------------------------------------
	// interpolation factor select codes
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_2X = 2'h0; // first stage only
	localparam logic [1:0] SEL_4X = 2'h1; // two stages
	localparam logic [1:0] SEL_8X = 2'h2; // three stages
	localparam logic [1:0] SEL_16X = 2'h3; // all four stages
	localparam int NUM_STAGES = 4; // cascaded half-band stages
	localparam int FIFO_DEPTH = 16; // input buffer depth in words

	// ------------------------------------------------------------
	// half-band coefficients, outermost nonzero tap first
	// ------------------------------------------------------------
	localparam int MAX_PAIRS = 15; // widest stage has 15 tap pairs
	localparam int HB_PAIRS [NUM_STAGES] = '{15, 6, 3, 3};
	localparam int HB_SHIFT [NUM_STAGES] = '{16, 14, 11, 8}; // log2 of centre
	localparam int HB_CENTER [NUM_STAGES] = '{65536, 16384, 2048, 256};
	localparam int HB_COEF [NUM_STAGES][MAX_PAIRS] = '{
		'{6, -19, 47, -100, 192, -342, 572, -914, 1409, -2119, 3152, -4729, 7420,
			-13334, 41527},
		'{-12, 84, -336, 1006, -2691, 10141, 0, 0, 0, 0, 0, 0, 0, 0, 0},
		'{29, -214, 1209, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
		'{3, -25, 150, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}
	};

	// ------------------------------------------------------------
	// inverse-sinc equaliser coefficients
	// ------------------------------------------------------------
	localparam int EQ_TAPS = 9; // symmetric, centre at index 4
	localparam int EQ_HALF = 4; // pairs around the centre
	localparam int EQ_COEF [EQ_HALF] = '{1, -4, 13, -50};
	localparam int EQ_CENTER = 592; // centre tap
	localparam int EQ_SHIFT = 9; // tap sum is 512

	// ------------------------------------------------------------
	// round half up, then clamp to the datapath range
	// ------------------------------------------------------------
	function automatic smp_t round_sat(input acc_t acc, input int sh);
		acc_t r;
		r = (acc + (acc_t'(1) <<< (sh - 1))) >>> sh;
		if (r > acc_t'(32767)) begin
			return 16'sh7FFF;
		end else if (r < acc_t'(-32768)) begin
			return 16'sh8000;
		end
		return smp_t'(r[DATA_W-1:0]);
	endfunction

endpackage

// ---- rtl/interpolation_filter_chain.sv ----
// input fifo, half-band interpolating stages and inverse-sinc equaliser
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// input sample fifo
// ------------------------------------------------------------
module sample_fifo #(
	parameter int WIDTH = interp_pkg::SAMPLE_W,
	parameter int DEPTH = interp_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH); // depth must be a power of two

	logic [WIDTH-1:0] mem [DEPTH]; // sample storage, no reset needed
	logic [AW:0] wptr_q, wptr_d; // write pointer with wrap bit
	logic [AW:0] rptr_q, rptr_d; // read pointer with wrap bit
	logic push, pop; // accepted transfers this cycle

	// full when the pointers differ only in the wrap bit
	always_comb begin
		in_ready_o = !((wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
		out_valid_o = (wptr_q != rptr_q);
		out_data_o = mem[rptr_q[AW-1:0]];
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		wptr_d = push ? wptr_q + {{AW{1'b0}}, 1'b1} : wptr_q;
		rptr_d = pop ? rptr_q + {{AW{1'b0}}, 1'b1} : rptr_q;
	end

	// pointers reset, storage just captures
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wptr_q[AW-1:0]] <= in_data_i;
		end
	end
endmodule

// ------------------------------------------------------------
// one half-band 2x interpolating stage
// ------------------------------------------------------------
module halfband_stage #(
	parameter int STAGE = 0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// input stream at the stage input rate
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire interp_pkg::sample_s in_i,
	// output stream at twice the rate
	output logic out_valid_o,
	input wire logic out_ready_i,
	output interp_pkg::sample_s out_o
);
	localparam int P = interp_pkg::HB_PAIRS[STAGE]; // nonzero tap pairs
	localparam int WLEN = 2 * P; // input samples spanned by the taps

	typedef enum logic [1:0] {HB_EMPTY, HB_EVEN, HB_ODD} hb_state_e;

	hb_state_e st_q, st_d; // which polyphase output is pending
	interp_pkg::smp_t wi_q [WLEN]; // in-phase delay line, newest at 0
	interp_pkg::smp_t wi_d [WLEN];
	interp_pkg::smp_t wq_q [WLEN]; // quadrature delay line
	interp_pkg::smp_t wq_d [WLEN];

	// polyphase form of zero-stuff-then-filter: the even phase sees only
	// the centre tap, the odd phase sees only the nonzero odd taps, so the
	// zeros are never multiplied
	function automatic interp_pkg::smp_t hb_out(input interp_pkg::smp_t w [WLEN],
		input logic odd);
		interp_pkg::acc_t acc;
		acc = '0;
		if (odd) begin
			for (int k = 0; k < P; k++) begin
				acc = acc + interp_pkg::acc_t'(interp_pkg::HB_COEF[STAGE][k])
					* (interp_pkg::acc_t'(w[k]) + interp_pkg::acc_t'(w[WLEN-1-k]));
			end
		end else begin
			acc = interp_pkg::acc_t'(interp_pkg::HB_CENTER[STAGE])
				* interp_pkg::acc_t'(w[P]);
		end
		return interp_pkg::round_sat(acc, interp_pkg::HB_SHIFT[STAGE]);
	endfunction

	// each accepted sample yields an even then an odd output
	always_comb begin
		st_d = st_q;
		wi_d = wi_q;
		wq_d = wq_q;
		in_ready_o = (st_q == HB_EMPTY) || ((st_q == HB_ODD) && out_ready_i);
		out_valid_o = (st_q != HB_EMPTY);
		if (in_valid_i && in_ready_o) begin
			for (int k = WLEN - 1; k > 0; k--) begin
				wi_d[k] = wi_q[k-1];
				wq_d[k] = wq_q[k-1];
			end
			wi_d[0] = in_i.i;
			wq_d[0] = in_i.q;
			st_d = HB_EVEN;
		end else if (out_ready_i) begin
			case (st_q)
				HB_EVEN: begin
					st_d = HB_ODD;
				end
				HB_ODD: begin
					st_d = HB_EMPTY;
				end
				default: begin
					st_d = st_q;
				end
			endcase
		end
		// same filter on both channels, no cross terms
		out_o.i = hb_out(wi_q, st_q == HB_ODD);
		out_o.q = hb_out(wq_q, st_q == HB_ODD);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= HB_EMPTY;
			wi_q <= '{default: '0};
			wq_q <= '{default: '0};
		end else begin
			st_q <= st_d;
			wi_q <= wi_d;
			wq_q <= wq_d;
		end
	end
endmodule

// ------------------------------------------------------------
// chain top
// ------------------------------------------------------------
module interpolation_filter_chain (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// configuration
	input wire logic [1:0] interp_sel_i,
	// upstream sample stream
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire interp_pkg::sample_s in_sample_i,
	// towards mixer and converter cores
	output logic out_valid_o,
	output interp_pkg::sample_s out_sample_o
);
	localparam int N = interp_pkg::NUM_STAGES;

	logic v [N+1]; // stream valid between stages
	logic r [N+1]; // stream ready between stages
	interp_pkg::sample_s d [N+1]; // stream data between stages
	logic [interp_pkg::SAMPLE_W-1:0] fifo_data; // fifo word out

	// one clock for the buffer and everything after it
	sample_fifo #(
		.WIDTH(interp_pkg::SAMPLE_W),
		.DEPTH(interp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(in_valid_i),
		.in_ready_o(in_ready_o),
		.in_data_i(in_sample_i),
		.out_valid_o(v[0]),
		.out_ready_i(r[0]),
		.out_data_o(fifo_data)
	);

	assign d[0] = interp_pkg::sample_s'(fifo_data);

	// a disabled stage is stepped around; changing the select mid-stream
	// may drop the samples held in a stage, so change it while idle
	for (genvar k = 0; k < N; k++) begin : g_stage
		logic en; // stage k is part of the cascade
		logic st_rdy; // stage input ready
		logic st_v; // stage output valid
		interp_pkg::sample_s st_d; // stage output data

		assign en = (int'(interp_sel_i) >= k);

		halfband_stage #(
			.STAGE(k)
		) u_hb (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.in_valid_i(v[k] && en),
			.in_ready_o(st_rdy),
			.in_i(d[k]),
			.out_valid_o(st_v),
			.out_ready_i(r[k+1]),
			.out_o(st_d)
		);

		assign r[k] = en ? st_rdy : r[k+1];
		assign v[k+1] = en ? st_v : v[k];
		assign d[k+1] = en ? st_d : d[k];
	end

	// the equaliser never stalls: it takes a sample on any cycle one exists
	assign r[N] = 1'b1;

	// ------------------------------------------------------------
	// inverse-sinc equaliser
	// ------------------------------------------------------------
	interp_pkg::smp_t ei_q [interp_pkg::EQ_TAPS]; // in-phase taps
	interp_pkg::smp_t ei_d [interp_pkg::EQ_TAPS];
	interp_pkg::smp_t eq_q [interp_pkg::EQ_TAPS]; // quadrature taps
	interp_pkg::smp_t eq_d [interp_pkg::EQ_TAPS];
	logic out_valid_d; // next output valid
	interp_pkg::sample_s out_sample_d; // next output sample

	// gain is unity at dc and rises with frequency, so a full-scale step can clip here
	function automatic interp_pkg::smp_t eq_out(input interp_pkg::smp_t w [interp_pkg::EQ_TAPS]);
		interp_pkg::acc_t acc;
		acc = interp_pkg::acc_t'(interp_pkg::EQ_CENTER)
			* interp_pkg::acc_t'(w[interp_pkg::EQ_HALF]);
		for (int k = 0; k < interp_pkg::EQ_HALF; k++) begin
			acc = acc + interp_pkg::acc_t'(interp_pkg::EQ_COEF[k])
				* (interp_pkg::acc_t'(w[k])
				+ interp_pkg::acc_t'(w[interp_pkg::EQ_TAPS-1-k]));
		end
		return interp_pkg::round_sat(acc, interp_pkg::EQ_SHIFT);
	endfunction

	// shift in a sample, emit the filtered one in the next cycle
	always_comb begin
		ei_d = ei_q;
		eq_d = eq_q;
		out_valid_d = v[N];
		if (v[N]) begin
			for (int k = interp_pkg::EQ_TAPS - 1; k > 0; k--) begin
				ei_d[k] = ei_q[k-1];
				eq_d[k] = eq_q[k-1];
			end
			ei_d[0] = d[N].i;
			eq_d[0] = d[N].q;
		end
		out_sample_d.i = v[N] ? eq_out(ei_d) : out_sample_o.i;
		out_sample_d.q = v[N] ? eq_out(eq_d) : out_sample_o.q;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ei_q <= '{default: '0};
			eq_q <= '{default: '0};
			out_valid_o <= 1'b0;
			out_sample_o <= '0;
		end else begin
			ei_q <= ei_d;
			eq_q <= eq_d;
			out_valid_o <= out_valid_d;
			out_sample_o <= out_sample_d;
		end
	end
endmodule

`default_nettype wire

// ---- tb/interpolation_filter_chain_monitor.sv ----
// port-level assertions for the interpolation filter chain
`timescale 1ns/1ps
`default_nettype none
module interpolation_filter_chain_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// configuration and streams
	input wire logic [1:0] interp_sel_i,
	input wire logic in_valid_i,
	input wire logic in_ready_o,
	input wire interp_pkg::sample_s in_sample_i,
	input wire logic out_valid_o,
	input wire interp_pkg::sample_s out_sample_o
);
	// ----
	// helper counters
	// ----
	int credit_q, credit_d; // outputs still owed for accepted words
	int idle_q, idle_d; // cycles since the last accepted word
	logic take; // word accepted this cycle
	assign take = in_valid_i && in_ready_o;
	// owed count grows by the factor; select must not move while busy
	always_comb begin
		credit_d = credit_q - int'(out_valid_o);
		if (take) begin
			credit_d = credit_d + (2 << interp_sel_i);
		end
		idle_d = take ? 0 : (idle_q < 1000 ? idle_q + 1 : idle_q);
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			credit_q <= 0;
			idle_q <= 0;
		end else begin
			credit_q <= credit_d;
			idle_q <= idle_d;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ----
	// assertions
	// ----
	a_sample_hold: assert property (!out_valid_o |-> $stable(out_sample_o))
		else $error("output sample moved without valid");
	a_credit_bound: assert property (credit_q >= 0)
		else $error("more outputs than the factor allows");
	a_credit_drained: assert property (idle_q > 600 |-> credit_q == 0)
		else $error("output count differs from the factor");
	a_idle_silent: assert property (idle_q > 600 |-> !out_valid_o)
		else $error("output without pending input");
	a_idle_ready: assert property (idle_q > 600 |-> in_ready_o)
		else $error("buffer not empty after long idle");
	a_early_quiet: assert property (take && credit_q == 0 |=> !out_valid_o)
		else $error("output too soon after first word");
	a_first_out: assert property (take && credit_q == 0 |-> ##[2:24] out_valid_o)
		else $error("first output late");
	a_ready_fall: assert property ($fell(in_ready_o) |-> $past(take))
		else $error("buffer filled without a write");
endmodule
bind interpolation_filter_chain interpolation_filter_chain_monitor u_interpolation_filter_chain_monitor (
	.clk_i, .rst_n_i, .interp_sel_i, .in_valid_i, .in_ready_o, .in_sample_i,
	.out_valid_o, .out_sample_o);
`default_nettype wire

// ---- tb/sample_source.sv ----
// upstream sample source model feeding the chain
`timescale 1ns/1ps
`default_nettype none
module sample_source (
	// clock
	input wire logic clk_i,
	// command from the bench
	input wire logic go_i,
	input wire logic [15:0] count_i,
	input wire interp_pkg::sample_s word_i,
	// stream towards the chain
	output logic in_valid_o,
	input wire logic in_ready_i,
	output interp_pkg::sample_s in_sample_o,
	output logic busy_o
);
	// time-zero values, then one burst per go, back to back, each word
	// held until taken; one process keeps every output single-driven
	initial begin
		in_valid_o = 1'b0;
		in_sample_o = '0;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i === 1'b1) begin
				@(negedge clk_i);
				busy_o = 1'b1;
				for (int k = 0; k < int'(count_i); k++) begin
					in_valid_o = 1'b1;
					in_sample_o = word_i;
					@(posedge clk_i);
					while (in_ready_i !== 1'b1) begin
						@(posedge clk_i);
					end
					@(negedge clk_i);
				end
				// idle data inverted so a stale word cannot pass as valid
				in_valid_o = 1'b0;
				in_sample_o = ~word_i;
				busy_o = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/interpolation_filter_chain_tb.sv ----
// self-checking bench for the interpolation filter chain
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
	$display("MISMATCH %s expected %0d seen %0d", nm, ex, got); end end
module interpolation_filter_chain_tb;
	// ----
	// stimulus and observation
	// ----
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] interp_sel_i = 2'h0;
	logic go = 1'b0; // burst request to the source
	logic [15:0] count = 16'h0000; // words per burst
	interp_pkg::sample_s word = '0;
	logic in_valid_i, in_ready_o, out_valid_o, busy;
	interp_pkg::sample_s in_sample_i, out_sample_o;
	int failures = 0;
	int checks = 0;
	int outs = 0; // output pulses seen
	logic saw_full = 1'b0; // buffer refused at least once
	interp_pkg::smp_t peak_hi, peak_lo, trough_q;
	always #50 clk_i = ~clk_i;
	interpolation_filter_chain u_interpolation_filter_chain (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.interp_sel_i(interp_sel_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
		.in_sample_i(in_sample_i), .out_valid_o(out_valid_o), .out_sample_o(out_sample_o));
	sample_source u_sample_source (.clk_i(clk_i), .go_i(go), .count_i(count), .word_i(word),
		.in_valid_o(in_valid_i), .in_ready_i(in_ready_o), .in_sample_o(in_sample_i),
		.busy_o(busy));
	// tally outputs at the falling edge, where they are settled
	always @(negedge clk_i) begin
		if (out_valid_o === 1'b1) begin
			outs++;
			if (out_sample_o.i > peak_hi) peak_hi = out_sample_o.i;
			if (out_sample_o.i < peak_lo) peak_lo = out_sample_o.i;
			if (out_sample_o.q < trough_q) trough_q = out_sample_o.q;
		end
		if (in_ready_o === 1'b0) saw_full = 1'b1;
	end
	// ----
	// shared tasks
	// ----
	task automatic launch(input logic [1:0] s, input int n, input interp_pkg::sample_s w);
		interp_sel_i = s;
		word = w;
		count = 16'(n);
		@(negedge clk_i) go = 1'b1;
		@(negedge clk_i) go = 1'b0;
		@(negedge clk_i);
		for (int k = 0; k < 2000 && busy === 1'b1; k++) @(negedge clk_i);
	endtask
	// end when output has been quiet a while; gaps are short
	task automatic drain();
		int q;
		q = 0;
		for (int k = 0; k < 3000 && q < 40; k++) begin
			@(negedge clk_i);
			q = (out_valid_o === 1'b1) ? 0 : q + 1;
		end
	endtask
	// ----
	// scenarios
	// ----
	// every factor: pulse count and exact dc on both channels
	task automatic test_factors();
		for (int s = 0; s < 4; s++) begin
			outs = 0;
			launch(2'(s), 40, '{i: 16'sd12345, q: -16'sd321});
			drain();
			`CHK("out_count", 40 * (2 << s), outs)
			`CHK("dc_i", 12345, out_sample_o.i)
			`CHK("dc_q", -321, out_sample_o.q)
		end
		`CHK("buffer_full", 1'b1, saw_full)
		`CHK("buffer_empty", 1'b1, in_ready_o)
	endtask
	// full-scale step overshoots: must clamp, never wrap
	task automatic test_clip();
		peak_hi = -16'sd32768;
		peak_lo = 16'sd32767;
		trough_q = 16'sd32767;
		launch(2'h0, 40, '{i: 16'sd32767, q: -16'sd32768});
		drain();
		`CHK("clip_hi", 32767, peak_hi)
		`CHK("clip_q", -32768, trough_q)
		`CHK("no_wrap", 1'b1, peak_lo > 0)
	endtask
	// long idle stays silent, reset while output still flows clears the pipe
	task automatic test_reset();
		outs = 0;
		repeat (700) @(negedge clk_i);
		`CHK("idle_outs", 0, outs)
		launch(2'h3, 16, '{i: 16'sd100, q: 16'sd200});
		repeat (20) @(negedge clk_i);
		rst_n_i = 1'b0;
		@(negedge clk_i);
		`CHK("rst_valid", 1'b0, out_valid_o)
		`CHK("rst_sample", 32'h0000_0000, out_sample_o)
		`CHK("rst_ready", 1'b1, in_ready_o)
		rst_n_i = 1'b1;
		outs = 0;
		launch(2'h1, 3, '{i: 16'sd100, q: 16'sd200});
		drain();
		`CHK("post_reset", 12, outs)
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// main sequence after sixteen cycles of reset
	initial begin
		repeat (16) @(negedge clk_i);
		rst_n_i = 1'b1;
		test_factors();
		test_clip();
		test_reset();
		print_verdict();
	end
	// watchdog well past the expected run length
	initial begin
		#2000000;
		failures++;
		print_verdict();
	end
endmodule
`default_nettype wire
